/* File: core/fiap_flash_iap_control.v */
// Flash in-application programming sequencer with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`include "fiap_defs.vh"

module fiap_flash_iap_control #(
    parameter UNLOCK_CYC = `FIAP_UNLOCK_CYC,  // Unlock window in clock cycles
    parameter AW         = 13,                // Flash word address width
    parameter WORDS      = 32                 // Words per page and buffer
) (
    input  wire          i_core_clk,       // System clock, 50 MHz
    input  wire          i_srst,           // Synchronous reset, active high
    input  wire [5:0]    i_avs_address,    // Byte address
    input  wire          i_avs_read,       // Read request
    input  wire          i_avs_write,      // Write request
    input  wire [31:0]   i_avs_writedata,  // Write data
    input  wire [3:0]    i_avs_byteenable, // Byte enables
    output reg  [31:0]   o_avs_readdata,   // Read data
    output wire          o_avs_waitrequest,// Wait request
    output wire [1:0]    o_avs_response,   // 00 ok, 10 slave error
    output wire          o_cpu_stall,      // Halts CPU during an operation
    output reg           o_chip_reset,     // Whole-chip reset pulse
    output reg           o_fl_erase,       // Erase strobe to array
    output reg           o_fl_write,       // Program strobe to array
    output reg           o_fl_read,        // Read strobe to array
    output reg  [AW-1:0] o_fl_addr,        // Array word address
    output reg  [15:0]   o_fl_wdata,       // Array write data
    output reg  [WORDS-1:0] o_fl_mask,     // Words selected for erase/write
    input  wire          i_fl_done,        // Array operation finished
    input  wire [15:0]   i_fl_rdata        // Array read data
);

    localparam S_IDLE  = 5'b00001;
    localparam S_ERASE = 5'b00010;
    localparam S_PROG  = 5'b00100;
    localparam S_READ  = 5'b01000;
    localparam S_WIPE  = 5'b10000;

    reg [4:0]        state_q;
    reg [AW-1:0]     addr_q;
    reg [7:0]        w0_lo_q;
    reg [7:0]        w0_hi_q;
    reg [7:0]        kd_q [0:5];
    reg              granted_q;
    reg [2:0]        op_q;
    reg              unlock_q;
    reg              prog_q;
    reg              rd_permit_q;
    reg              rd_start_q;
    reg              wipe_q;
    reg [31:0]       unlock_cnt_q;
    reg [4:0]        rst_cnt_q;
    reg [15:0]       wbuf_q [0:WORDS-1];
    reg [WORDS-1:0]  tag_q;
    reg [4:0]        wr_idx_q;
    reg              ack_q;
    reg              err_q;
    reg [15:0]       rdata_q;
    reg              wr_wait_q;
    reg [31:0]       rd_mux;

    wire             req = i_avs_read | i_avs_write;
    wire             wr = i_avs_write & ack_q;
    wire             busy = (state_q != S_IDLE);
    wire [7:0]       wb = i_avs_writedata[7:0];
    wire             wr_lane = i_avs_byteenable[0];
    wire             key_ok;
    wire             mapped;
    integer          i;

    // One wait cycle per access keeps the decode registered
    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_response    = err_q ? 2'h2 : 2'h0;
    assign o_cpu_stall       = busy;

    assign key_ok = (kd_q[0] == `FIAP_KEY1_LO) && (kd_q[2] == `FIAP_KEY2_LO) &&
                    (kd_q[4] == `FIAP_KEY3_LO) && (kd_q[1] == `FIAP_KEY1_HI) &&
                    (kd_q[3] == `FIAP_KEY2_HI) && (kd_q[5] == `FIAP_KEY3_HI);
    assign mapped = (i_avs_address[1:0] == 2'h0) && (i_avs_address <= `FIAP_OFS_STATUS);

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            ack_q          <= 1'b0;
            err_q          <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            ack_q          <= req & ~ack_q;
            err_q          <= req & ~ack_q & ~mapped;
            // Latched in the wait cycle so it stands through the acknowledge cycle
            o_avs_readdata <= (i_avs_read & ~ack_q) ? rd_mux : 32'h0;
        end
    end

    always @* begin
        rd_mux = 32'h0;
        case (i_avs_address)
            `FIAP_OFS_ADDR_LO:  rd_mux[7:0] = addr_q[7:0];
            `FIAP_OFS_ADDR_HI:  rd_mux[AW-9:0] = addr_q[AW-1:8];
            `FIAP_OFS_W0_LO:    rd_mux[7:0] = w0_lo_q;
            `FIAP_OFS_W0_HI:    rd_mux[7:0] = w0_hi_q;
            `FIAP_OFS_KD1_LO:   rd_mux[7:0] = kd_q[0];
            `FIAP_OFS_KD1_HI:   rd_mux[7:0] = kd_q[1];
            `FIAP_OFS_KD2_LO:   rd_mux[7:0] = kd_q[2];
            `FIAP_OFS_KD2_HI:   rd_mux[7:0] = kd_q[3];
            `FIAP_OFS_KD3_LO:   rd_mux[7:0] = kd_q[4];
            `FIAP_OFS_KD3_HI:   rd_mux[7:0] = kd_q[5];
            `FIAP_OFS_MAIN_CTL: rd_mux[7:0] = {granted_q, op_q, unlock_q, prog_q,
                                               rd_permit_q, rd_start_q};
            `FIAP_OFS_RST_KEY:  rd_mux[7:0] = 8'h00;
            `FIAP_OFS_WIPE_CTL: rd_mux[7:0] = {7'h00, wipe_q};
            `FIAP_OFS_STATUS:   rd_mux[15:0] = rdata_q;
            default:            rd_mux = 32'h0;
        endcase
    end

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            state_q      <= S_IDLE;
            addr_q       <= {AW{1'b0}};
            w0_lo_q      <= 8'h00;
            w0_hi_q      <= 8'h00;
            granted_q    <= 1'b0;
            op_q         <= 3'h0;
            unlock_q     <= 1'b0;
            prog_q       <= 1'b0;
            rd_permit_q  <= 1'b0;
            rd_start_q   <= 1'b0;
            wipe_q       <= 1'b0;
            unlock_cnt_q <= 32'h0;
            rst_cnt_q    <= 5'h0;
            tag_q        <= {WORDS{1'b0}};
            wr_idx_q     <= 5'h0;
            wr_wait_q    <= 1'b0;
            rdata_q      <= 16'h0000;
            o_chip_reset <= 1'b0;
            o_fl_erase   <= 1'b0;
            o_fl_write   <= 1'b0;
            o_fl_read    <= 1'b0;
            o_fl_addr    <= {AW{1'b0}};
            o_fl_wdata   <= 16'h0000;
            o_fl_mask    <= {WORDS{1'b0}};
            for (i = 0; i < 6; i = i + 1)
                kd_q[i] <= 8'h00;
            for (i = 0; i < WORDS; i = i + 1)
                wbuf_q[i] <= 16'h0000;
        end else begin
            o_fl_erase <= 1'b0;
            o_fl_write <= 1'b0;
            o_fl_read  <= 1'b0;
            // Chip reset pulse held long enough for the reset tree
            if (rst_cnt_q != 5'h0) begin
                rst_cnt_q    <= rst_cnt_q - 5'h1;
                o_chip_reset <= 1'b1;
            end else begin
                o_chip_reset <= 1'b0;
            end
            // Register writes land only when idle, the CPU being stalled while busy; a clear of the granted bit lands while busy too
            if (wr && wr_lane && !busy) begin
                case (i_avs_address)
                    `FIAP_OFS_ADDR_LO: addr_q[7:0] <= wb;
                    `FIAP_OFS_ADDR_HI: addr_q[AW-1:8] <= wb[AW-9:0];
                    `FIAP_OFS_W0_LO:   w0_lo_q <= wb;
                    `FIAP_OFS_W0_HI: begin
                        w0_hi_q <= wb;
                        wbuf_q[addr_q[4:0]] <= {wb, w0_lo_q};
                        tag_q[addr_q[4:0]]  <= 1'b1;
                        if (addr_q[4:0] != `FIAP_PAGE_LAST)
                            addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
                    end
                    `FIAP_OFS_KD1_LO:  kd_q[0] <= wb;
                    `FIAP_OFS_KD1_HI:  kd_q[1] <= wb;
                    `FIAP_OFS_KD2_LO:  kd_q[2] <= wb;
                    `FIAP_OFS_KD2_HI:  kd_q[3] <= wb;
                    `FIAP_OFS_KD3_LO:  kd_q[4] <= wb;
                    `FIAP_OFS_KD3_HI:  kd_q[5] <= wb;
                    `FIAP_OFS_MAIN_CTL: begin
                        if (!wb[`FIAP_B_GRANTED])
                            granted_q <= 1'b0;
                        op_q        <= wb[`FIAP_B_OP_HI:`FIAP_B_OP_LO];
                        rd_permit_q <= wb[`FIAP_B_RD_PERMIT];
                        if (wb[`FIAP_B_UNLOCK] && !unlock_q) begin
                            unlock_q     <= 1'b1;
                            unlock_cnt_q <= 32'h0;
                        end
                        // Launch only in a mode that permits it
                        if (wb[`FIAP_B_PROG] && granted_q && wb[`FIAP_B_GRANTED]) begin
                            if (wb[6:4] == `FIAP_OP_ERASE) begin
                                prog_q     <= 1'b1;
                                state_q    <= S_ERASE;
                                o_fl_erase <= 1'b1;
                                o_fl_addr  <= {addr_q[AW-1:5], 5'h00};
                                o_fl_mask  <= tag_q;
                            end else if (wb[6:4] == `FIAP_OP_WRITE) begin
                                prog_q    <= 1'b1;
                                state_q   <= S_PROG;
                                wr_idx_q  <= 5'h0;
                                wr_wait_q <= 1'b0;
                            end
                        end else if (wb[`FIAP_B_RD_START] && rd_permit_q &&
                                     wb[`FIAP_B_RD_PERMIT] &&
                                     wb[6:4] == `FIAP_OP_READ) begin
                            rd_start_q <= 1'b1;
                            state_q    <= S_READ;
                            o_fl_read  <= 1'b1;
                            o_fl_addr  <= addr_q;
                        end
                    end
                    `FIAP_OFS_RST_KEY:
                        if (wb == `FIAP_CHIP_RST_KEY)
                            rst_cnt_q <= `FIAP_RST_PULSE_CYC;
                    `FIAP_OFS_WIPE_CTL:
                        if (wb[`FIAP_B_WIPE]) begin
                            wipe_q  <= 1'b1;
                            state_q <= S_WIPE;
                        end
                    default: ;
                endcase
            end else if (wr && wr_lane && i_avs_address == `FIAP_OFS_MAIN_CTL &&
                         !wb[`FIAP_B_GRANTED]) begin
                granted_q <= 1'b0;
            end
            // Unlock timer after the writes: a grant at expiry beats a same-cycle clear
            if (unlock_q) begin
                if (unlock_cnt_q >= UNLOCK_CYC - 1) begin
                    unlock_q <= 1'b0;
                    if (key_ok && op_q == `FIAP_OP_UNLOCK)
                        granted_q <= 1'b1;
                end else begin
                    unlock_cnt_q <= unlock_cnt_q + 32'h1;
                end
            end
            case (state_q)
                S_IDLE: ;
                S_ERASE: begin
                    if (!granted_q) begin
                        prog_q  <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (i_fl_done) begin
                        prog_q  <= 1'b0;
                        tag_q   <= {WORDS{1'b0}};
                        state_q <= S_IDLE;
                    end
                end
                S_PROG: begin
                    // One strobe per word; the next waits for the array's answer
                    if (!granted_q) begin
                        prog_q    <= 1'b0;
                        wr_wait_q <= 1'b0;
                        state_q   <= S_IDLE;
                    end else if (!wr_wait_q) begin
                        wr_wait_q  <= 1'b1;
                        o_fl_write <= 1'b1;
                        o_fl_addr  <= {addr_q[AW-1:5], wr_idx_q};
                        o_fl_wdata <= wbuf_q[wr_idx_q];
                        o_fl_mask  <= tag_q;
                    end else if (i_fl_done) begin
                        wr_wait_q <= 1'b0;
                        if (wr_idx_q == `FIAP_PAGE_LAST) begin
                            prog_q  <= 1'b0;
                            tag_q   <= {WORDS{1'b0}};
                            state_q <= S_WIPE;
                        end else begin
                            wr_idx_q <= wr_idx_q + 5'h1;
                        end
                    end
                end
                S_READ: begin
                    if (!rd_permit_q) begin
                        rd_start_q <= 1'b0;
                        state_q    <= S_IDLE;
                    end else if (i_fl_done) begin
                        rdata_q    <= i_fl_rdata;
                        rd_start_q <= 1'b0;
                        state_q    <= S_IDLE;
                    end
                end
                S_WIPE: begin
                    for (i = 0; i < WORDS; i = i + 1)
                        wbuf_q[i] <= 16'h0000;
                    wipe_q  <= 1'b0;
                    state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule // fiap_flash_iap_control

/* File: core/fiap_defs.vh */
// Register map, field positions and timing constants of the flash IAP controller
`ifndef FIAP_DEFS_VH
`define FIAP_DEFS_VH

`define FIAP_OFS_ADDR_LO     6'h00
`define FIAP_OFS_ADDR_HI     6'h04
`define FIAP_OFS_W0_LO       6'h08
`define FIAP_OFS_W0_HI       6'h0c
`define FIAP_OFS_KD1_LO      6'h10
`define FIAP_OFS_KD1_HI      6'h14
`define FIAP_OFS_KD2_LO      6'h18
`define FIAP_OFS_KD2_HI      6'h1c
`define FIAP_OFS_KD3_LO      6'h20
`define FIAP_OFS_KD3_HI      6'h24
`define FIAP_OFS_MAIN_CTL    6'h28
`define FIAP_OFS_RST_KEY     6'h2c
`define FIAP_OFS_WIPE_CTL    6'h30
`define FIAP_OFS_STATUS      6'h34

`define FIAP_B_GRANTED       7
`define FIAP_B_OP_HI         6
`define FIAP_B_OP_LO         4
`define FIAP_B_UNLOCK        3
`define FIAP_B_PROG          2
`define FIAP_B_RD_PERMIT     1
`define FIAP_B_RD_START      0
`define FIAP_B_WIPE          0

`define FIAP_OP_WRITE        3'h0
`define FIAP_OP_ERASE        3'h1
`define FIAP_OP_READ         3'h3
`define FIAP_OP_UNLOCK       3'h6

`define FIAP_KEY1_LO         8'h00
`define FIAP_KEY2_LO         8'h0d
`define FIAP_KEY3_LO         8'hc3
`define FIAP_KEY1_HI         8'h04
`define FIAP_KEY2_HI         8'h09
`define FIAP_KEY3_HI         8'h40
`define FIAP_CHIP_RST_KEY    8'h55

`define FIAP_PAGE_LAST       5'h1f
`define FIAP_CLK_MHZ         50
`define FIAP_UNLOCK_US       64
`define FIAP_UNLOCK_CYC      (`FIAP_UNLOCK_US * `FIAP_CLK_MHZ)
`define FIAP_RST_PULSE_CYC   5'h10

`endif

/* File: verification/fiap_flash_model.sv */
// Behavioural flash array answering the sequencer's strobes
`timescale 1ns/10ps
module fiap_flash_model (
    input  wire        i_core_clk, // Clock
    input  wire        i_srst,     // Sync reset
    input  wire        i_slow,     // Long answer delay
    input  wire        i_erase,    // Erase strobe
    input  wire        i_write,    // Program strobe
    input  wire        i_read,     // Read strobe
    input  wire [12:0] i_addr,     // Word address
    input  wire [15:0] i_wdata,    // Write data
    input  wire [31:0] i_mask,     // Erase tags
    output reg         o_done,     // Finished pulse
    output reg  [15:0] o_rdata     // Read data, valid with done
);
    reg [15:0] mem [0:255];
    reg [7:0]  ra;
    reg        rd_pend;
    integer    cnt;
    integer    k;
    always @(posedge i_core_clk) begin
        o_done <= 1'b0;
        // Data toggles outside done so a stale value never passes
        o_rdata <= ~o_rdata;
        if (i_srst) begin
            cnt <= 0;
            rd_pend <= 1'b0;
            o_rdata <= 16'h0000;
        end else if (i_erase || i_write || i_read) begin
            cnt <= i_slow ? 40 : 2;
            ra <= i_addr[7:0];
            rd_pend <= i_read;
            if (i_write)
                mem[i_addr[7:0]] <= i_wdata;
            for (k = 0; k < 32; k = k + 1)
                if (i_erase && i_mask[k])
                    mem[{i_addr[7:5], k[4:0]}] <= 16'h0000;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_done <= 1'b1;
            if (rd_pend)
                o_rdata <= mem[ra];
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // fiap_flash_model

/* File: verification/fiap_iap_chk.sv */
// Port-level assertions for the flash IAP sequencer
`timescale 1ns/10ps
module fiap_iap_chk #(
    parameter AW    = 13, // Address width
    parameter WORDS = 32  // Page words
) (
    input wire             i_core_clk,        // Clock
    input wire             i_srst,            // Reset
    input wire [5:0]       i_avs_address,     // Address
    input wire             i_avs_read,        // Read
    input wire             i_avs_write,       // Write
    input wire [31:0]      i_avs_writedata,   // Write data
    input wire [3:0]       i_avs_byteenable,  // Lanes
    input wire [31:0]      o_avs_readdata,    // Read data
    input wire             o_avs_waitrequest, // Wait
    input wire [1:0]       o_avs_response,    // Response
    input wire             o_cpu_stall,       // Stall
    input wire             o_chip_reset,      // Chip reset
    input wire             o_fl_erase,        // Erase strobe
    input wire             o_fl_write,        // Program strobe
    input wire             o_fl_read,         // Read strobe
    input wire [AW-1:0]    o_fl_addr,         // Array address
    input wire [15:0]      o_fl_wdata,        // Array data
    input wire [WORDS-1:0] o_fl_mask,         // Tags
    input wire             i_fl_done,         // Array done
    input wire [15:0]      i_fl_rdata         // Array data in
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    wire req = i_avs_read || i_avs_write;
    wire ack = req && !o_avs_waitrequest;
    wire wr0 = ack && i_avs_write && i_avs_byteenable[0] && !o_cpu_stall;
    chk_wait_one_cycle: assert property (req && !$past(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("waitrequest not one cycle");
    chk_bad_addr_resp: assert property (ack && i_avs_address >= 6'h38 |-> o_avs_response == 2'b10)
        else $error("unmapped access not flagged");
    chk_bad_addr_zero: assert property (ack && i_avs_read && i_avs_address >= 6'h38 |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_good_addr_resp: assert property (ack && i_avs_address <= 6'h34 |-> o_avs_response == 2'b00)
        else $error("mapped access flagged");
    chk_wipe_high_zero: assert property (ack && i_avs_read && i_avs_address == 6'h30 |-> o_avs_readdata[31:1] == 31'h0)
        else $error("wipe register high bits set");
    chk_strobe_stalls: assert property (o_fl_erase || o_fl_write || o_fl_read |-> o_cpu_stall)
        else $error("array strobe without stall");
    chk_one_op_strobe: assert property ($onehot0({o_fl_erase, o_fl_write, o_fl_read}))
        else $error("two operations at once");
    chk_chip_reset_key: assert property (wr0 && i_avs_address == 6'h2c && i_avs_writedata[7:0] == 8'h55 |-> ##[1:2] o_chip_reset [*8])
        else $error("chip reset pulse missing");
    chk_no_false_reset: assert property (wr0 && i_avs_address == 6'h2c && i_avs_writedata[7:0] != 8'h55 && !o_chip_reset |=> !o_chip_reset)
        else $error("chip reset on wrong key");
    chk_relock_quiet: assert property (wr0 && i_avs_address == 6'h28 && !i_avs_writedata[7] |=> (!o_fl_erase && !o_fl_write) [*8])
        else $error("erase or write after relock");
endmodule // fiap_iap_chk

bind fiap_flash_iap_control fiap_iap_chk #(.AW(AW), .WORDS(WORDS)) u_chk (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .o_cpu_stall(o_cpu_stall), .o_chip_reset(o_chip_reset), .o_fl_erase(o_fl_erase),
    .o_fl_write(o_fl_write), .o_fl_read(o_fl_read), .o_fl_addr(o_fl_addr),
    .o_fl_wdata(o_fl_wdata), .o_fl_mask(o_fl_mask), .i_fl_done(i_fl_done),
    .i_fl_rdata(i_fl_rdata));

/* File: verification/fiap_testbench.sv */
// Self-checking bench for the flash IAP sequencer
`timescale 1ns/10ps
`include "fiap_defs.vh"
module testbench;
    reg         clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, slow = 1'b0;
    reg  [5:0]  adr = 6'h00;
    reg  [31:0] wd = 32'h0, q, er_mask;
    reg  [1:0]  rsp_s;
    wire [31:0] rdat, fm;
    wire [1:0]  rsp;
    wire        wreq, stall, crst, fe, fw, fr, done;
    wire [12:0] fa;
    wire [15:0] fwd, read_start;
    integer     failures = 0, n_compared = 0, cyc = 0, n_er = 0, n_wr = 0, n_rd = 0, n_crst = 0;
    fiap_flash_iap_control #(.UNLOCK_CYC(60)) DUT (
        .i_core_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_avs_response(rsp),
        .o_cpu_stall(stall), .o_chip_reset(crst), .o_fl_erase(fe), .o_fl_write(fw),
        .o_fl_read(fr), .o_fl_addr(fa), .o_fl_wdata(fwd), .o_fl_mask(fm),
        .i_fl_done(done), .i_fl_rdata(read_start));
    fiap_flash_model u_flash (.i_core_clk(clk), .i_srst(srst), .i_slow(slow), .i_erase(fe),
        .i_write(fw), .i_read(fr), .i_addr(fa), .i_wdata(fwd), .i_mask(fm),
        .o_done(done), .o_rdata(read_start));
    initial begin
        forever #10 clk = ~clk;
    end
    // Strobe counters sample mid-cycle, clear of the edge that launches them
    always @(negedge clk) begin
        if (fe)
            er_mask = fm;
        n_er = n_er + fe;
        n_wr = n_wr + fw;
        n_rd = n_rd + fr;
        n_crst = n_crst + crst;
        cyc = cyc + 1;
        if (cyc == 30000) begin
            failures = failures + 1;
            give_verdict;
        end
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[FAIL] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task bus(input w, input [5:0] a, input [7:0] d);
        begin
            @(posedge clk);
            rd <= !w;
            wr <= w;
            adr <= a;
            wd <= {24'h0, d};
            do @(posedge clk); while (wreq !== 1'b0);
            q = rdat;
            rsp_s = rsp;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task wait_bit(input string nm, input [5:0] a, input integer b, input v);
        integer i;
        begin
            bus(1'b0, a, 8'h00);
            for (i = 0; i < 300 && q[b] !== v; i = i + 1)
                bus(1'b0, a, 8'h00);
            chk(nm, {31'h0, v}, {31'h0, q[b]});
        end
    endtask
    task t_regs;
        integer a;
        begin
            for (a = 0; a <= 6'h30; a = a + 4) begin
                bus(1'b0, a[5:0], 8'h00);
                chk("reset value", 32'h0, q);
            end
            for (a = 6'h10; a <= 6'h24; a = a + 4) begin
                bus(1'b1, a[5:0], a[7:0] ^ 8'ha5);
                bus(1'b0, a[5:0], 8'h00);
                chk("key data", {24'h0, a[7:0] ^ 8'ha5}, q);
            end
            bus(1'b1, 6'h38, 8'hff);
            bus(1'b0, 6'h38, 8'h00);
            chk("unmapped", 32'h2, {q[29:0], rsp_s});
            bus(1'b1, `FIAP_OFS_WIPE_CTL, 8'hff);
            bus(1'b0, `FIAP_OFS_WIPE_CTL, 8'h00);
            chk("wipe ctl", 32'h0, q);
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h80);
            bus(1'b0, `FIAP_OFS_MAIN_CTL, 8'h00);
            chk("granted by write", 32'h0, q);
            $display("test regs done");
        end
    endtask
    task t_unlock(input [7:0] last, input g);
        reg [47:0] k;
        integer    i;
        begin
            k = {8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, last};
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h60);
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h68);
            for (i = 0; i < 6; i = i + 1)
                bus(1'b1, 6'h10 + 4 * i, k[47 - 8 * i -: 8]);
            wait_bit("unlock trigger", `FIAP_OFS_MAIN_CTL, 3, 1'b0);
            chk("granted", {31'h0, g}, {31'h0, q[7]});
            $display("test unlock done");
        end
    endtask
    task t_erase;
        begin
            bus(1'b1, 6'h00, 8'h1e);
            repeat (3) bus(1'b1, 6'h0c, 8'h5a);
            bus(1'b0, 6'h00, 8'h00);
            chk("addr hold", 32'h1f, q);
            slow <= 1'b1;
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h94);
            repeat (2) @(negedge clk);
            chk("stall", 32'h1, {31'h0, stall});
            wait_bit("erase done", `FIAP_OFS_MAIN_CTL, 2, 1'b0);
            chk("erase tags", 32'hc000_0000, er_mask);
            chk("erase count", 1, n_er);
            slow <= 1'b0;
            $display("test erase done");
        end
    endtask
    task t_wr_rd;
        begin
            bus(1'b1, 6'h00, 8'h00);
            bus(1'b1, 6'h04, 8'h01);
            bus(1'b1, 6'h08, 8'h34);
            bus(1'b1, 6'h0c, 8'h12);
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h84);
            wait_bit("write done", `FIAP_OFS_MAIN_CTL, 2, 1'b0);
            chk("write count", 32, n_wr);
            bus(1'b1, 6'h00, 8'h00);
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h82);
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'hb3);
            wait_bit("read done", `FIAP_OFS_MAIN_CTL, 0, 1'b0);
            bus(1'b0, `FIAP_OFS_STATUS, 8'h00);
            chk("read data", 32'h1234, q);
            $display("test write read done");
        end
    endtask
    task t_relock;
        begin
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h31);
            repeat (20) @(posedge clk);
            chk("read blocked", 1, n_rd);
            bus(1'b0, `FIAP_OFS_MAIN_CTL, 8'h00);
            chk("relocked", 32'h0, {31'h0, q[7]});
            bus(1'b1, `FIAP_OFS_MAIN_CTL, 8'h94);
            repeat (20) @(posedge clk);
            chk("erase locked", 1, n_er);
            $display("test relock done");
        end
    endtask
    task t_chip_rst;
        begin
            bus(1'b1, `FIAP_OFS_RST_KEY, 8'h54);
            repeat (20) @(posedge clk);
            chk("no chip reset", 0, n_crst);
            bus(1'b1, `FIAP_OFS_RST_KEY, 8'h55);
            repeat (30) @(posedge clk);
            chk("chip reset", 16, n_crst);
            $display("test chip reset done");
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_unlock(8'h41, 1'b0);
        t_unlock(8'h40, 1'b1);
        t_erase;
        t_wr_rd;
        t_relock;
        t_chip_rst;
        give_verdict;
    end
endmodule // testbench
